/* File: poserr_pkg.sv */
// package: error codes, buffer addresses and limits for the error checker
// assumes: shared buffer addresses are word indices, codes are decimal bytes
package poserr_pkg;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CALC_TIMEOUT = 8'h32; // 50
  localparam logic [7:0] ERR_CALC_FAULT = 8'h33; // 51
  localparam logic [7:0] ERR_POINTER = 8'h3C; // 60
  localparam logic [7:0] ERR_SPEED_CHG = 8'h3D; // 61
  localparam logic [7:0] ERR_PV_CHG = 8'h3E; // 62
  localparam logic [7:0] ERR_CPU_RDY_WR = 8'h3F; // 63
  localparam logic [7:0] ERR_PROTECTED = 8'h40; // 64
  localparam logic [7:0] ERR_DRV_NOT_RDY = 8'h46; // 70
  localparam logic [7:0] ERR_EXT_STOP = 8'h47; // 71
  localparam logic [7:0] ERR_NOT_READY = 8'h48; // 72
  localparam logic [7:0] ERR_BUSY = 8'h49; // 73
  localparam logic [7:0] ERR_COMPLETE = 8'h4A; // 74
  localparam logic [7:0] ERR_AUX_CODE = 8'h4B; // 75
  localparam logic [7:0] ERR_STOP_CMD = 8'h4C; // 76
  localparam logic [7:0] ERR_ZRET_REPEAT = 8'h4D; // 77
  localparam logic [7:0] ERR_ZRET_DONE = 8'h4E; // 78
  localparam logic [7:0] ERR_RANGE = 8'h4F; // 79
  localparam logic [7:0] ERR_DRV_LOST = 8'h50; // 80
  localparam logic [7:0] ERR_ZRET_STOP = 8'h51; // 81
  // buffer addresses: per-axis fields x axis then y axis, then the cpu-ready write range
  localparam logic [12:0] ADDR_PTR_X = 13'h0027; // 39
  localparam logic [12:0] ADDR_PTR_Y = 13'h0153; // 339
  localparam logic [12:0] ADDR_SPD_X = 13'h0028; // 40
  localparam logic [12:0] ADDR_SPD_Y = 13'h0154; // 340
  localparam logic [12:0] ADDR_PV0_X = 13'h0029; // 41
  localparam logic [12:0] ADDR_PV1_X = 13'h002A; // 42
  localparam logic [12:0] ADDR_PV0_Y = 13'h0155; // 341
  localparam logic [12:0] ADDR_PV1_Y = 13'h0156; // 342
  localparam logic [12:0] ADDR_CPU_LO = 13'h1EC0; // 7872
  localparam logic [12:0] ADDR_CPU_HI = 13'h1EF8; // 7928
  localparam logic [31:0] POS_MAX = 32'h00F8_0000; // 16252928 pulses
  localparam logic [15:0] PTR_LAST = 16'h0014; // 20th point
  localparam logic [1:0] ZRET_MAX = 2'h2; // more than twice is refused
  // bus starvation: device waits this long for a buffer slot
  localparam int BUS_WAIT_NS = 10000;
  localparam int CLK_NS = 10;
  localparam int BUS_WAIT_CYC = BUS_WAIT_NS / CLK_NS;
  // start kinds
  localparam logic [1:0] START_POS = 2'h0;
  localparam logic [1:0] START_ZRET = 2'h1;
  localparam logic [1:0] START_JOG = 2'h2;
  localparam logic [1:0] START_INCH = 2'h3;
endpackage

/* File: poserr_start_check.sv */
// start check for one axis: picks the refusal code of highest priority
// assumes: all inputs already synchronised to i_clk
module poserr_start_check (
  input wire logic [1:0] i_kind,
  input wire logic i_drv_ready,
  input wire logic i_ext_stop,
  input wire logic i_ready_ok,
  input wire logic i_busy,
  input wire logic i_complete,
  input wire logic i_aux_active,
  input wire logic i_stop_cmd,
  input wire logic i_zret_repeat,
  input wire logic i_zret_done,
  input wire logic [31:0] i_position,
  output logic [7:0] o_code
);
  // first failing check wins, in table order
  always_comb begin
    o_code = poserr_pkg::ERR_NONE;
    if (!i_drv_ready) begin
      o_code = poserr_pkg::ERR_DRV_NOT_RDY;
    end else if (i_ext_stop) begin
      o_code = poserr_pkg::ERR_EXT_STOP;
    end else if (!i_ready_ok) begin
      o_code = poserr_pkg::ERR_NOT_READY;
    end else if (i_busy) begin
      o_code = poserr_pkg::ERR_BUSY;
    end else if (i_complete) begin
      o_code = poserr_pkg::ERR_COMPLETE;
    end else if (i_aux_active) begin
      o_code = poserr_pkg::ERR_AUX_CODE;
    end else if (i_stop_cmd) begin
      o_code = poserr_pkg::ERR_STOP_CMD;
    end else if (i_kind == poserr_pkg::START_ZRET && i_zret_repeat) begin
      o_code = poserr_pkg::ERR_ZRET_REPEAT;
    end else if (i_kind == poserr_pkg::START_ZRET && i_zret_done) begin
      o_code = poserr_pkg::ERR_ZRET_DONE;
    end else if (i_position > poserr_pkg::POS_MAX) begin
      o_code = poserr_pkg::ERR_RANGE;
    end
  end
endmodule

/* File: positioning_error_checker.sv */
// error detection and reporting for a two-axis positioning module
// assumes: host strobes and device status come from logic on i_clk;
// drive ready and external stops are pins and are synchronised here
//
// Overview of operation
// - arithmetic unit timeout raises hold error code 50, a hardware fault.
// - arithmetic overflow, underflow or failure raises hold error code 51.
// - host buffer access wins; device starved too long gives bus hold error.
// - any hold error drops module ready, aborts busy and refuses starts.
// - code 61 on speed change write during interpolated motion.
// - code 62 on present value change write while axis busy.
// - code 63 on host write to 7872..7928 while host CPU ready is on.
// - code 64 on host write into a write-protected buffer region.
// - refuse start with code 70 when drive unit ready is off.
// - refuse start with code 71 when an external stop input is on.
// - refuse start with code 72 when module and host ready are both off.
// - refuse start with code 73 when the axis is already busy.
// - refuse start with code 74 while positioning complete flag is on.
// - refuse start with code 75 while auxiliary code flag is on.
// - refuse start with code 76 on axis stop command or peripheral break.
// - refuse zero return with code 77 when repeated more than twice.
// - refuse zero return with code 78 when zero return already complete.
// - refuse start with code 79 when position outside 0..16252928 pulses.
// - interpolated start posts the error code on both axes.
// - loss of drive ready while busy reports code 80.
// - zero return stopped before completion reports code 81.
module positioning_error_checker #(
  parameter int BUS_WAIT = poserr_pkg::BUS_WAIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host buffer writes
  input wire logic i_host_req,
  input wire logic i_host_wr,
  input wire logic [12:0] i_host_addr,
  input wire logic [15:0] i_host_wdata,
  input wire logic i_host_protected,
  input wire logic i_host_cpu_ready,
  input wire logic i_x_axis_stop_cmd,
  input wire logic i_y_axis_stop_cmd,
  input wire logic i_peripheral_break,
  input wire logic [1:0] i_err_clear,
  // start request: one-cycle pulses
  input wire logic [1:0] i_start,
  input wire logic [1:0] i_start_kind,
  input wire logic i_interp,
  // device status
  input wire logic [1:0] i_busy,
  input wire logic [1:0] i_complete,
  input wire logic [1:0] i_aux_active,
  input wire logic [1:0] i_zret_done,
  input wire logic [1:0] i_zret_stopped,
  input wire logic [1:0] i_point_reached_20,
  input wire logic [15:0] i_ptr_x,
  input wire logic [15:0] i_ptr_y,
  input wire logic [31:0] i_pos_x,
  input wire logic [31:0] i_pos_y,
  input wire logic i_dev_buf_req,
  input wire logic i_calc_timeout,
  input wire logic i_calc_fault,
  // pins from the drive unit
  input wire logic [1:0] i_drv_ready,
  input wire logic i_x_external_stop_in,
  input wire logic i_y_external_stop_in,
  output logic o_module_ready_out,
  output logic o_hold,
  output logic [7:0] o_hold_code,
  output logic [1:0] o_abort,
  output logic [1:0] o_start_ok,
  output logic o_dev_buf_gnt,
  output logic [7:0] o_err_x,
  output logic [7:0] o_err_y
);
  logic [1:0] drv_meta;
  logic [1:0] drv_sync;
  logic [1:0] stop_meta;
  logic [1:0] stop_sync;
  logic [31:0] wait_cnt;
  logic [1:0] zret_cnt_x;
  logic [1:0] zret_cnt_y;
  logic [1:0] drv_prev_busy;
  logic [7:0] start_code_x;
  logic [7:0] start_code_y;
  logic [7:0] next_err_x;
  logic [7:0] next_err_y;
  logic [7:0] wr_code_x;
  logic [7:0] wr_code_y;
  logic host_write;
  logic bus_starved;
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // decide whether an address belongs to an axis field pair
  function automatic logic addr_is(input logic [12:0] a,
                                   input logic [12:0] b0,
                                   input logic [12:0] b1);
    addr_is = (a == b0) || (a == b1);
  endfunction

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  // two flops each; only the second is read by logic
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      drv_meta <= 2'h0;
      drv_sync <= 2'h0;
      stop_meta <= 2'h0;
      stop_sync <= 2'h0;
    end else begin
      drv_meta <= i_drv_ready;
      drv_sync <= drv_meta;
      stop_meta <= {i_y_external_stop_in, i_x_external_stop_in};
      stop_sync <= stop_meta;
    end
  end

  // =====================================================================
  // buffer arbitration and hold errors
  // =====================================================================
  assign host_write = i_host_req && i_host_wr;
  // host always wins; device only gets the idle slot
  assign o_dev_buf_gnt = i_dev_buf_req && !i_host_req;
  assign bus_starved = (wait_cnt >= 32'(BUS_WAIT - 1)) && i_dev_buf_req
                       && i_host_req;

  // count how long the device has been waiting for the buffer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_dev_buf_req || !i_host_req) begin
      wait_cnt <= 32'h0;
    end else if (!bus_starved) begin
      wait_cnt <= wait_cnt + 32'h1;
    end
  end

  // hold error is sticky until reset: a hardware fault needs restart
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hold <= 1'b0;
      o_hold_code <= poserr_pkg::ERR_NONE;
    end else if (!o_hold) begin
      if (i_calc_timeout) begin
        o_hold <= 1'b1;
        o_hold_code <= poserr_pkg::ERR_CALC_TIMEOUT;
      end else if (i_calc_fault) begin
        o_hold <= 1'b1;
        o_hold_code <= poserr_pkg::ERR_CALC_FAULT;
      end else if (bus_starved) begin
        o_hold <= 1'b1; // bus error carries no numeric code
      end
    end
  end

  // ready falls and busy aborts as long as hold stands
  assign o_module_ready_out = i_rst_n && !o_hold;
  assign o_abort = {2{o_hold}};

  // =====================================================================
  // start checks
  // =====================================================================
  poserr_start_check u_chk_x (
    .i_kind(i_start_kind),
    .i_drv_ready(drv_sync[0]),
    .i_ext_stop(stop_sync[0]),
    .i_ready_ok(o_module_ready_out || i_host_cpu_ready),
    .i_busy(i_busy[0]),
    .i_complete(i_complete[0]),
    .i_aux_active(i_aux_active[0]),
    .i_stop_cmd(i_x_axis_stop_cmd || i_peripheral_break),
    .i_zret_repeat(zret_cnt_x >= poserr_pkg::ZRET_MAX),
    .i_zret_done(i_zret_done[0]),
    .i_position(i_pos_x),
    .o_code(start_code_x)
  );
  poserr_start_check u_chk_y (
    .i_kind(i_start_kind),
    .i_drv_ready(drv_sync[1]),
    .i_ext_stop(stop_sync[1]),
    .i_ready_ok(o_module_ready_out || i_host_cpu_ready),
    .i_busy(i_busy[1]),
    .i_complete(i_complete[1]),
    .i_aux_active(i_aux_active[1]),
    .i_stop_cmd(i_y_axis_stop_cmd || i_peripheral_break),
    .i_zret_repeat(zret_cnt_y >= poserr_pkg::ZRET_MAX),
    .i_zret_done(i_zret_done[1]),
    .i_position(i_pos_y),
    .o_code(start_code_y)
  );

  // accepted start pulse; interpolation needs both axes clean
  always_comb begin
    o_start_ok = 2'h0;
    if (!o_hold) begin
      if (i_interp) begin
        o_start_ok = {2{(i_start != 2'h0) && start_code_x == 8'h00
                        && start_code_y == 8'h00}};
      end else begin
        o_start_ok[0] = i_start[0] && start_code_x == 8'h00;
        o_start_ok[1] = i_start[1] && start_code_y == 8'h00;
      end
    end
  end

  // consecutive zero return counters; any other start kind resets them
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      zret_cnt_x <= 2'h0;
      zret_cnt_y <= 2'h0;
    end else begin
      if (i_start[0] && i_start_kind != poserr_pkg::START_ZRET) begin
        zret_cnt_x <= 2'h0;
      end else if (i_start[0] && zret_cnt_x != 2'h3) begin
        zret_cnt_x <= zret_cnt_x + 2'h1;
      end
      if (i_start[1] && i_start_kind != poserr_pkg::START_ZRET) begin
        zret_cnt_y <= 2'h0;
      end else if (i_start[1] && zret_cnt_y != 2'h3) begin
        zret_cnt_y <= zret_cnt_y + 2'h1;
      end
    end
  end

  // =====================================================================
  // buffer write checks
  // =====================================================================
  // one code per axis; protected and cpu-ready checks post on the x axis only
  always_comb begin
    wr_code_x = poserr_pkg::ERR_NONE;
    wr_code_y = poserr_pkg::ERR_NONE;
    if (host_write) begin
      if (i_host_protected) begin
        wr_code_x = poserr_pkg::ERR_PROTECTED;
      end else if (i_host_cpu_ready && i_host_addr >= poserr_pkg::ADDR_CPU_LO
                   && i_host_addr <= poserr_pkg::ADDR_CPU_HI) begin
        wr_code_x = poserr_pkg::ERR_CPU_RDY_WR;
      end else if (i_host_addr == poserr_pkg::ADDR_PTR_X && i_busy[0]) begin
        wr_code_x = poserr_pkg::ERR_POINTER;
      end else if (i_host_addr == poserr_pkg::ADDR_PTR_Y && i_busy[1]) begin
        wr_code_y = poserr_pkg::ERR_POINTER;
      end else if (addr_is(i_host_addr, poserr_pkg::ADDR_SPD_X,
                           poserr_pkg::ADDR_SPD_Y) && i_interp
                   && i_busy != 2'h0) begin
        wr_code_x = poserr_pkg::ERR_SPEED_CHG;
        wr_code_y = poserr_pkg::ERR_SPEED_CHG;
      end else if (addr_is(i_host_addr, poserr_pkg::ADDR_PV0_X,
                           poserr_pkg::ADDR_PV1_X) && i_busy[0]) begin
        wr_code_x = poserr_pkg::ERR_PV_CHG;
      end else if (addr_is(i_host_addr, poserr_pkg::ADDR_PV0_Y,
                           poserr_pkg::ADDR_PV1_Y) && i_busy[1]) begin
        wr_code_y = poserr_pkg::ERR_PV_CHG;
      end
    end
    // pointer left nonzero past the last point
    if (i_point_reached_20[0] && i_ptr_x != 16'h0) begin
      wr_code_x = poserr_pkg::ERR_POINTER;
    end
    if (i_point_reached_20[1] && i_ptr_y != 16'h0) begin
      wr_code_y = poserr_pkg::ERR_POINTER;
    end
  end

  // =====================================================================
  // error code registers
  // =====================================================================
  // priority: hold, busy-time, start refusal, write error, clear
  always_comb begin
    next_err_x = o_err_x;
    next_err_y = o_err_y;
    if (i_err_clear[0]) next_err_x = poserr_pkg::ERR_NONE;
    if (i_err_clear[1]) next_err_y = poserr_pkg::ERR_NONE;
    if (wr_code_x != 8'h00) next_err_x = wr_code_x;
    if (wr_code_y != 8'h00) next_err_y = wr_code_y;
    if (i_start != 2'h0 && i_interp
        && (start_code_x != 8'h00 || start_code_y != 8'h00)) begin
      next_err_x = (start_code_x != 8'h00) ? start_code_x : start_code_y;
      next_err_y = (start_code_y != 8'h00) ? start_code_y : start_code_x;
    end else begin
      if (i_start[0] && start_code_x != 8'h00) next_err_x = start_code_x;
      if (i_start[1] && start_code_y != 8'h00) next_err_y = start_code_y;
    end
    if (i_zret_stopped[0]) next_err_x = poserr_pkg::ERR_ZRET_STOP;
    if (i_zret_stopped[1]) next_err_y = poserr_pkg::ERR_ZRET_STOP;
    if (drv_prev_busy[0] && !drv_sync[0]) begin
      next_err_x = poserr_pkg::ERR_DRV_LOST;
    end
    if (drv_prev_busy[1] && !drv_sync[1]) begin
      next_err_y = poserr_pkg::ERR_DRV_LOST;
    end
    if (o_hold_code != 8'h00) begin
      next_err_x = o_hold_code;
      next_err_y = o_hold_code;
    end
  end

  // latched codes for the host; new errors beat a clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_err_x <= poserr_pkg::ERR_NONE;
      o_err_y <= poserr_pkg::ERR_NONE;
      drv_prev_busy <= 2'h0;
    end else begin
      o_err_x <= next_err_x;
      o_err_y <= next_err_y;
      drv_prev_busy <= i_busy & drv_sync;
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  AST_TIMEOUT_CODE: assert property (!o_hold && i_calc_timeout
    |=> o_hold_code == 8'h32)
    else $error("timeout did not post code 50");
  AST_FAULT_CODE: assert property (!o_hold && !i_calc_timeout
    && i_calc_fault |=> o_hold_code == 8'h33)
    else $error("calc fault did not post code 51");
  AST_HOST_PRIO: assert property (i_host_req |-> !o_dev_buf_gnt)
    else $error("device granted over host");
  AST_HOLD_STOPS: assert property (o_hold |-> !o_module_ready_out
    && o_abort == 2'h3 && o_start_ok == 2'h0)
    else $error("hold did not stop the module");
  AST_BUSY_START: assert property (i_start[0] && !i_interp
    && i_busy[0] |-> !o_start_ok[0])
    else $error("busy axis started");
  AST_DRV_START: assert property (!o_hold && i_start[0] && !i_interp
    && !drv_sync[0] && !i_zret_stopped[0] && !(drv_prev_busy[0])
    |=> o_err_x == 8'h46)
    else $error("drive not ready start not coded 70");
  AST_INTERP_BOTH: assert property (!o_hold && i_interp
    && i_start != 2'h0 && start_code_x != 8'h00 && i_zret_stopped == 2'h0
    && drv_prev_busy == 2'h0 |=> o_err_y != 8'h00)
    else $error("interpolated error not on both axes");
  AST_DRV_LOST: assert property (!o_hold && $fell(drv_sync[0])
    && $past(i_busy[0]) |=> o_err_x == 8'h50)
    else $error("drive loss while busy not coded 80");
  AST_ZRET_STOP: assert property (!o_hold && i_zret_stopped[1]
    && !(drv_prev_busy[1] && !drv_sync[1]) |=> o_err_y == 8'h51)
    else $error("stopped zero return not coded 81");
  COV_START: cover property (@(posedge i_clk) o_start_ok[0]);
  COV_HOLD: cover property (@(posedge i_clk) $rose(o_hold));
  COV_WRITE_ERR: cover property (@(posedge i_clk) wr_code_x == 8'h3E);
endmodule

/* File: drv_unit_model.sv */
// drive unit model: ready and external stop pins seen by the checker
// assumes: the bench commands ready loss and stops through plain inputs
module drv_unit_model (
  input wire logic i_clk,
  input wire logic [1:0] i_fail,
  input wire logic i_stop,
  output logic [1:0] o_drv_ready,
  output logic o_x_external_stop_in,
  output logic o_y_external_stop_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_drv_ready = 2'h3;
    o_x_external_stop_in = 1'b0;
    o_y_external_stop_in = 1'b0;
  end
  // ========================================
  // pin drive
  // pins move 3 ns after the i_clk edge, as a unit on its own clock would
  always @(posedge i_clk) begin
    o_drv_ready <= #3 ~i_fail;
    o_x_external_stop_in <= #3 i_stop;
    o_y_external_stop_in <= #3 1'b0;
  end
endmodule

/* File: tb.sv */
// self-checking bench for the error checker: host side and drive unit
// assumes: codes land in o_err_x within two edges of the request edge
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  err_count++; $display("unexpected %s exp %0d got %0d", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, host_req = 0, host_wr = 0, prot = 0, cpu_rdy = 1;
  logic xstop = 0, ystop = 0, brk = 0, interp = 0, dev_req = 0;
  logic tmo = 0, cfault = 0, ext = 0, held = 0;
  logic [15:0] ptr = 0;
  logic [1:0] clr = 0, start = 0, kind = 0, busy = 0, cmp = 0, aux = 0;
  logic [1:0] zd = 0, zs = 0, fail = 0, pr20 = 0, drdy;
  logic [12:0] addr = 0;
  logic [31:0] pos_x = 0, rnd = 32'h5DE4E803;
  logic xe, ye, mrdy, hold, gnt;
  logic [7:0] hcode, err_x, err_y;
  logic [1:0] abort, sok;
  int err_count = 0, checks_done = 0, cyc = 0, zcnt = 0, m;
  always #5 clk = ~clk;
  drv_unit_model PARTNER (.i_clk(clk), .i_fail(fail), .i_stop(ext),
    .o_drv_ready(drdy), .o_x_external_stop_in(xe),
    .o_y_external_stop_in(ye));
  positioning_error_checker #(.BUS_WAIT(8)) DUT (.i_clk(clk),
    .i_rst_n(rst_n), .i_host_req(host_req), .i_host_wr(host_wr),
    .i_host_addr(addr), .i_host_wdata(16'h0000), .i_host_protected(prot),
    .i_host_cpu_ready(cpu_rdy), .i_x_axis_stop_cmd(xstop),
    .i_y_axis_stop_cmd(ystop), .i_peripheral_break(brk),
    .i_err_clear(clr), .i_start(start), .i_start_kind(kind),
    .i_interp(interp), .i_busy(busy), .i_complete(cmp),
    .i_aux_active(aux), .i_zret_done(zd), .i_zret_stopped(zs),
    .i_point_reached_20(pr20), .i_ptr_x(ptr), .i_ptr_y(16'h0000),
    .i_pos_x(pos_x), .i_pos_y(32'h0000_0000), .i_dev_buf_req(dev_req),
    .i_calc_timeout(tmo), .i_calc_fault(cfault), .i_drv_ready(drdy),
    .i_x_external_stop_in(xe), .i_y_external_stop_in(ye),
    .o_module_ready_out(mrdy), .o_hold(hold), .o_hold_code(hcode),
    .o_abort(abort), .o_start_ok(sok), .o_dev_buf_gnt(gnt),
    .o_err_x(err_x), .o_err_y(err_y));
  // ========================================
  // reference model and helpers
  // model of the x axis start checks, in priority order of the codes
  function automatic int model(input int k);
    if (fail[0]) return 70;
    if (ext) return 71;
    if (!cpu_rdy && held) return 72;
    if (busy[0]) return 73;
    if (cmp[0]) return 74;
    if (aux[0]) return 75;
    if (xstop || brk) return 76;
    if (k == 1 && zcnt >= 2) return 77;
    if (k == 1 && zd[0]) return 78;
    if (pos_x > 32'd16252928) return 79;
    if (interp && busy[1]) return 73;
    return 0;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // errors stand until cleared, so one pulse then a check of zero
  task automatic clear_err();
    @(posedge clk) clr <= 2'h3;
    @(posedge clk) clr <= 2'h0;
    cyc_n(1);
    `CHK("err_x clear", 8'h00, err_x)
  endtask
  task automatic go(input logic [1:0] k);
    @(posedge clk) begin start <= 2'h1; kind <= k; end
    // read the conditions after the edge so last-edge stimulus counts
    m = model(k);
    zcnt = (k == 2'h1) ? zcnt + 1 : 0;
    @(negedge clk) `CHK("start_ok", (m == 0), sok[0])
    @(posedge clk) start <= 2'h0;
    @(negedge clk) `CHK("err_x start", 8'(m), err_x)
  endtask
  task automatic wr(input logic [12:0] a, input logic p, input int e);
    @(posedge clk) begin host_req <= 1; host_wr <= 1; addr <= a; prot <= p; end
    @(posedge clk) begin host_req <= 0; host_wr <= 0; prot <= 0; end
    @(negedge clk) `CHK("err_x write", 8'(e), err_x)
    clear_err();
  endtask
  task automatic set_cond(input int c, input logic v);
    case (c)
      0: fail[0] <= v;
      1: ext <= v;
      2: busy[0] <= v;
      3: cmp[0] <= v;
      4: aux[0] <= v;
      5: xstop <= v;
      6: brk <= v;
      7: zd[0] <= v;
      default: pos_x <= v ? 32'd16252929 : 32'd0;
    endcase
  endtask
  task automatic do_reset();
    @(posedge clk) rst_n <= 0;
    cyc_n(5);
    rst_n <= 1;
    cyc_n(2);
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard: the whole run is well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // ========================================
  // scenarios
  initial begin
    do_reset();
    `CHK("ready", 1'b1, mrdy)
    for (int c = 0; c < 9; c++) begin
      set_cond(c, 1);
      cyc_n(5);
      go((c == 7) ? 2'h1 : 2'h0);
      set_cond(c, 0);
      cyc_n(5);
      clear_err();
    end
    // start codes of every start kind, zero return repeated thrice
    for (int k = 0; k < 4; k++) go(2'(k));
    for (int i = 0; i < 3; i++) go(2'h1);
    clear_err();
    go(2'h2);
    go(2'h1);
    clear_err();
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      @(posedge clk) pos_x <= rnd >> 8;
      go(2'h0);
      clear_err();
    end
    @(posedge clk) pos_x <= 0;
    // interpolated start with y busy posts the code on both axes
    @(posedge clk) begin interp <= 1; busy[1] <= 1; end
    go(2'h0);
    `CHK("err_y interp", 8'h49, err_y)
    @(posedge clk) busy <= 2'h1;
    wr(13'd40, 0, 61);
    @(posedge clk) interp <= 0;
    wr(13'd41, 0, 62);
    wr(13'd342, 0, 0);
    wr(13'd39, 0, 60);
    @(posedge clk) busy <= 2'h0;
    wr(13'd41, 0, 0);
    wr(13'd7872, 0, 63);
    wr(13'd7928, 0, 63);
    wr(13'd7929, 0, 0);
    wr(13'd100, 1, 64);
    @(posedge clk) begin pr20 <= 2'h1; ptr <= rnd[15:0] | 16'h0001; end
    @(posedge clk) begin pr20 <= 2'h0; ptr <= 16'h0000; end
    @(negedge clk) `CHK("err_x ptr", 8'd60, err_x)
    clear_err();
    // ready lost mid-move, then zero return cut short
    @(posedge clk) begin busy[0] <= 1; fail[0] <= 1; end
    cyc_n(6);
    `CHK("err_x lost", 8'd80, err_x)
    @(posedge clk) begin busy[0] <= 0; fail[0] <= 0; end
    cyc_n(5);
    clear_err();
    @(posedge clk) zs <= 2'h1;
    @(posedge clk) zs <= 2'h0;
    cyc_n(1);
    `CHK("err_x zstop", 8'd81, err_x)
    // starved device, then arithmetic timeout and fault
    @(posedge clk) begin dev_req <= 1; host_req <= 1; end
    @(negedge clk) `CHK("gnt", 1'b0, gnt)
    cyc_n(12);
    `CHK("bus hold", 8'h00, hcode)
    `CHK("abort", 2'h3, abort)
    cpu_rdy <= 1'b0;
    held = 1'b1;
    go(2'h0);
    @(posedge clk) begin dev_req <= 0; host_req <= 0; cpu_rdy <= 1; end
    held = 1'b0;
    do_reset();
    @(posedge clk) tmo <= 1;
    @(posedge clk) tmo <= 0;
    cyc_n(2);
    `CHK("hold code", 8'd50, hcode)
    `CHK("ready off", 1'b0, mrdy)
    @(posedge clk) start <= 2'h1;
    @(negedge clk) `CHK("hold start", 1'b0, sok[0])
    @(posedge clk) start <= 2'h0;
    do_reset();
    @(posedge clk) cfault <= 1;
    @(posedge clk) cfault <= 0;
    cyc_n(2);
    `CHK("hold code", 8'd51, hcode)
    `CHK("hold", 1'b1, hold)
    results();
  end
endmodule
